// ===== include/rpc_params.svh
// rpc_params.svh: constants for the reading phase controller
// assumes inclusion by bare name from the rtl and test files
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define RPC_CLK_HZ          10000000
`define RPC_TICK_MS         1
`define RPC_TICK_CYCLES     ((`RPC_CLK_HZ / 1000) * `RPC_TICK_MS)
`define RPC_TMO_MIN_MS      40
`define RPC_TMO_MAX_MS      15000
`define RPC_DEBOUNCE_DEF_MS 5

// -------------------------------------------------------------
// field positions and selector codes
// -------------------------------------------------------------
`define RPC_BUS_START_BIT   7
`define RPC_SEL_INPUT1      2'h0
`define RPC_SEL_INPUT3      2'h1
`define RPC_SEL_INPUT4      2'h2
`define RPC_CHAR_MAX        8'h7e
`define RPC_PIN_COUNT       4
`define RPC_PIN_IN1         0
`define RPC_PIN_IN3         2
`define RPC_PIN_IN4         3

`endif

// ===== include/rpc_pkg.sv
// rpc_pkg.sv: types for the reading phase controller
// needs nothing from rpc_params.svh, which it does not include
`default_nettype none

package rpc_pkg;

	// operating mode
	typedef enum logic [0:0] {
		RPC_MODE_ONLINE     = 1'b0,
		RPC_MODE_CONTINUOUS = 1'b1
	} rpc_mode_t;

	// on-line trigger source
	typedef enum logic [1:0] {
		RPC_SRC_ONE_INPUT = 2'h0,
		RPC_SRC_TWO_INPUT = 2'h1,
		RPC_SRC_SERIAL    = 2'h2
	} rpc_source_t;

	// input polarity
	typedef enum logic [0:0] {
		RPC_ACTIVE_OPEN   = 1'b0,
		RPC_ACTIVE_CLOSED = 1'b1
	} rpc_level_t;

	// phase state, one-hot
	typedef enum logic [2:0] {
		RPC_ST_IDLE   = 3'b001,
		RPC_ST_OPEN   = 3'b010,
		RPC_ST_EXTEND = 3'b100
	} rpc_state_t;

endpackage : rpc_pkg

`default_nettype wire

// ===== rtl/rpc_input_cond.sv
// rpc_input_cond.sv: synchroniser, polarity and debounce for one input
// assumes a one-cycle millisecond tick on the same clock
`include "rpc_params.svh"
`default_nettype none

module rpc_input_cond #(
	parameter int DEB_W = 8
) (
	input  wire logic                      clock,
	input  wire logic                      reset,
	input  wire logic [`RPC_PIN_COUNT-1:0] pins,
	input  wire logic [1:0]                pinSel,
	input  wire rpc_pkg::rpc_level_t       activeLevel,
	input  wire logic                      msTick,
	input  wire logic [DEB_W-1:0]          debounceMs,
	output logic                           rawActive,
	output logic                           stableActive
);
	import rpc_pkg::*;

	if (DEB_W < 1) begin : g_bad_params
		$error("rpc_input_cond: unsupported parameter values");
	end

	logic [`RPC_PIN_COUNT-1:0] sync1_q;
	logic [`RPC_PIN_COUNT-1:0] sync2_q;
	logic [1:0]                fill_q;
	logic                      pinNow;
	logic [DEB_W-1:0]          cnt_q;
	logic                      stable_q;

	// -------------------------------------------------------------
	// synchroniser: pins are selected only after both stages
	// -------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
			fill_q  <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			fill_q  <= {fill_q[0], 1'b1};
		end
	end

	always_comb begin
		pinNow = 1'b0;
		unique case (pinSel)
			`RPC_SEL_INPUT1: pinNow = sync2_q[`RPC_PIN_IN1];
			`RPC_SEL_INPUT3: pinNow = sync2_q[`RPC_PIN_IN3];
			`RPC_SEL_INPUT4: pinNow = sync2_q[`RPC_PIN_IN4];
			default:         pinNow = 1'b0;
		endcase
	end

	// polarity select
	// quiet until the stages hold a real sample, else active open fakes an edge
	assign rawActive = fill_q[1] && ((activeLevel == RPC_ACTIVE_CLOSED) ? pinNow : ~pinNow);

	// -------------------------------------------------------------
	// debounce: only the going-active edge is filtered
	// -------------------------------------------------------------
	// active for debounce time
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cnt_q    <= '0;
			stable_q <= 1'b0;
		end else if (!rawActive) begin
			cnt_q    <= '0;
			stable_q <= 1'b0;
		end else if (!stable_q && msTick) begin
			if (cnt_q >= debounceMs)
				stable_q <= 1'b1;
			else
				cnt_q <= cnt_q + 1'b1;
		end
	end

	assign stableActive = stable_q | (rawActive && debounceMs == '0);
endmodule : rpc_input_cond

`default_nettype wire

// ===== rtl/rpc_phase_ctrl.sv
// rpc_phase_ctrl.sv: reading phase controller, top level
// assumes async pins, and decoder and serial parser on this clock
`include "rpc_params.svh"
`default_nettype none

// Operation
// - on-line phase runs from on to off event
// - continuous phase always on, no no-read
// - one input: good-read at sensor end
// - one input: no-read at sensor end
// - two inputs: start opens, stop inactive closes
// - extended phase: stop needs start inactive
// - serial start and stop strings, timeout
// - serial good read raises good-read event
// - serial bad read raises no-read event
// - fieldbus bit 7 byte 0 drives start
// - start input from 1, 3 or 4
// - active open or active closed polarity
// - timeout limits phase, 40 to 15000 ms
// - timeout counts from start or stop
// - stop priority or always timeout
// - trigger accepted after debounce time
// - verifier compares code with reference
// - store input captures new reference code
// - store input uses same polarities
// - optionally transmit mismatching code
// - optionally send mismatch message
module rpc_phase_ctrl #(
	parameter int TICK_CYCLES = `RPC_TICK_CYCLES,
	parameter int CODE_LEN    = 32,
	parameter int TMO_W       = 14,
	parameter int DEB_W       = 8
) (
	input  wire logic                    clock,
	input  wire logic                    reset,
	input  wire logic [`RPC_PIN_COUNT-1:0] inputPins,
	input  wire rpc_pkg::rpc_mode_t      operatingMode,
	input  wire rpc_pkg::rpc_source_t    triggerSource,
	input  wire logic [1:0]              startInputSel,
	input  wire rpc_pkg::rpc_level_t     startActiveLevel,
	input  wire logic [1:0]              stopInputSel,
	input  wire rpc_pkg::rpc_level_t     stopActiveLevel,
	input  wire logic                    extendedPhase,
	input  wire logic                    busStartEnable,
	input  wire logic [7:0]              controlBitByte,
	input  wire logic                    timeoutEnable,
	input  wire logic [TMO_W-1:0]        timeoutMs,
	input  wire logic                    timeoutFromStop,
	input  wire logic                    stopPriorityTimeout,
	input  wire logic [DEB_W-1:0]        debounceMs,
	input  wire logic                    serialStartRx,
	input  wire logic                    serialStopRx,
	input  wire logic                    decodeValid,
	input  wire logic [8*CODE_LEN-1:0]   decodeData,
	input  wire logic                    verifierEnable,
	input  wire logic [1:0]              storeInputSel,
	input  wire rpc_pkg::rpc_level_t     storeActiveLevel,
	input  wire logic                    wrongCodeTxEnable,
	input  wire logic                    wrongStringTxEnable,
	output logic                         readingPhase,
	output logic                         goodReadEvent,
	output logic                         noReadEvent,
	output logic                         codeTxStrobe,
	output logic [8*CODE_LEN-1:0]        codeTxData,
	output logic                         noReadMsgStrobe,
	output logic                         wrongStringStrobe,
	output logic [8*CODE_LEN-1:0]        referenceCode,
	output logic                         timeoutValid
);
	import rpc_pkg::*;

	if (TICK_CYCLES < 1 || CODE_LEN < 1 || TMO_W < 14 || DEB_W < 1) begin : g_bad_params
		$error("rpc_phase_ctrl: unsupported parameter values");
	end

	localparam int TW = $clog2(TICK_CYCLES + 1);

	// -------------------------------------------------------------
	// millisecond tick
	// -------------------------------------------------------------
	logic [TW-1:0] tickCnt_q;
	logic          msTick;

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			tickCnt_q <= '0;
		else if (tickCnt_q == TW'(TICK_CYCLES - 1))
			tickCnt_q <= '0;
		else
			tickCnt_q <= tickCnt_q + 1'b1;
	end
	assign msTick = (tickCnt_q == TW'(TICK_CYCLES - 1));

	// -------------------------------------------------------------
	// input selection and conditioning
	// -------------------------------------------------------------
	logic startStable;
	logic stopStable;
	logic storeRaw;

	rpc_input_cond #(.DEB_W(DEB_W)) uStart (
		.clock        (clock),
		.reset        (reset),
		.pins         (inputPins),
		.pinSel       (startInputSel),
		.activeLevel  (startActiveLevel),
		.msTick       (msTick),
		.debounceMs   (debounceMs),
		.rawActive    (),
		.stableActive (startStable)
	);

	rpc_input_cond #(.DEB_W(DEB_W)) uStop (
		.clock        (clock),
		.reset        (reset),
		.pins         (inputPins),
		.pinSel       (stopInputSel),
		.activeLevel  (stopActiveLevel),
		.msTick       (msTick),
		.debounceMs   (debounceMs),
		.rawActive    (),
		.stableActive (stopStable)
	);

	rpc_input_cond #(.DEB_W(DEB_W)) uStore (
		.clock        (clock),
		.reset        (reset),
		.pins         (inputPins),
		.pinSel       (storeInputSel),
		.activeLevel  (storeActiveLevel),
		.msTick       (msTick),
		.debounceMs   ('0),
		.rawActive    (storeRaw),
		.stableActive ()
	);

	logic startLevel;
	assign startLevel = busStartEnable ? controlBitByte[`RPC_BUS_START_BIT] : startStable;

	logic startLevel_q;
	logic stopLevel_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			startLevel_q <= 1'b0;
			stopLevel_q  <= 1'b0;
		end else begin
			startLevel_q <= startLevel;
			stopLevel_q  <= stopStable;
		end
	end

	// -------------------------------------------------------------
	// phase on and off events per source
	// -------------------------------------------------------------
	logic onEvent;
	logic offEvent;
	logic startRise;
	logic startFall;
	logic stopFall;

	assign startRise = startLevel & ~startLevel_q;
	assign startFall = ~startLevel & startLevel_q;
	assign stopFall  = ~stopStable & stopLevel_q;

	always_comb begin
		onEvent  = 1'b0;
		offEvent = 1'b0;
		unique case (triggerSource)
			RPC_SRC_ONE_INPUT: begin
				onEvent  = startRise;
				offEvent = startFall;
			end
			RPC_SRC_TWO_INPUT: begin
				onEvent = startRise;
				offEvent = extendedPhase ? ((stopFall | (state_q == RPC_ST_EXTEND)) & ~startLevel)
				                         : stopFall;
			end
			RPC_SRC_SERIAL: begin
				onEvent  = serialStartRx;
				offEvent = serialStopRx;
			end
			default: begin
				onEvent  = 1'b0;
				offEvent = 1'b0;
			end
		endcase
	end

	// timeout in serial or one input
	logic tmoAllowed;
	assign tmoAllowed   = timeoutEnable && (triggerSource != RPC_SRC_TWO_INPUT);
	assign timeoutValid = timeoutMs >= TMO_W'(`RPC_TMO_MIN_MS) && timeoutMs <= TMO_W'(`RPC_TMO_MAX_MS);

	// -------------------------------------------------------------
	// phase state machine and timeout counter
	// -------------------------------------------------------------
	rpc_state_t       state_q;
	logic [TMO_W-1:0] tmoCnt_q;
	logic             tmoExpire;
	logic             phaseEnd;

	assign tmoExpire = tmoAllowed && msTick && (tmoCnt_q + 1'b1 >= timeoutMs);

	always_comb begin
		phaseEnd = 1'b0;
		unique case (state_q)
			RPC_ST_OPEN: begin
				if (!tmoAllowed || timeoutFromStop)
					phaseEnd = offEvent && !(tmoAllowed && timeoutFromStop);
				else if (stopPriorityTimeout)
					phaseEnd = tmoExpire;
				else
					phaseEnd = offEvent | tmoExpire;
			end
			RPC_ST_EXTEND: phaseEnd = tmoAllowed ? tmoExpire : offEvent;
			RPC_ST_IDLE:   phaseEnd = 1'b0;
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			state_q <= RPC_ST_IDLE;
		else if (operatingMode == RPC_MODE_CONTINUOUS)
			state_q <= RPC_ST_IDLE;
		else begin
			unique case (state_q)
				RPC_ST_IDLE:
					if (onEvent)
						state_q <= RPC_ST_OPEN;
				RPC_ST_OPEN:
					if ((tmoAllowed && timeoutFromStop && offEvent) ||
					    (triggerSource == RPC_SRC_TWO_INPUT && extendedPhase && stopFall && startLevel))
						state_q <= RPC_ST_EXTEND;
					else if (phaseEnd)
						state_q <= RPC_ST_IDLE;
				RPC_ST_EXTEND:
					if (phaseEnd)
						state_q <= RPC_ST_IDLE;
			endcase
		end
	end

	// counter restarts at start or stop
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			tmoCnt_q <= '0;
		else if (state_q == RPC_ST_IDLE || (state_q == RPC_ST_OPEN && timeoutFromStop))
			tmoCnt_q <= '0;
		else if (msTick)
			tmoCnt_q <= tmoCnt_q + 1'b1;
	end

	assign readingPhase = (operatingMode == RPC_MODE_CONTINUOUS) || (state_q != RPC_ST_IDLE);

	// -------------------------------------------------------------
	// decode result, verifier, output events
	// -------------------------------------------------------------
	logic                  gotCode_q;
	logic [8*CODE_LEN-1:0] lastCode_q;
	logic                  storeArmed_q;
	logic                  phaseClose;
	logic                  mismatch;

	assign phaseClose = (state_q != RPC_ST_IDLE) && phaseEnd && operatingMode == RPC_MODE_ONLINE;
	assign mismatch = verifierEnable && !storeArmed_q && (lastCode_q != referenceCode);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			gotCode_q  <= 1'b0;
			lastCode_q <= '0;
		end else if (decodeValid && readingPhase) begin
			gotCode_q  <= 1'b1;
			lastCode_q <= decodeData;
		end else if (state_q == RPC_ST_IDLE)
			gotCode_q <= 1'b0;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			storeArmed_q <= 1'b0;
		else if (state_q == RPC_ST_IDLE && onEvent)
			storeArmed_q <= verifierEnable && storeRaw;
		else if (state_q == RPC_ST_IDLE)
			storeArmed_q <= 1'b0;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			referenceCode <= '0;
		else if (phaseClose && storeArmed_q && gotCode_q)
			referenceCode <= lastCode_q;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			goodReadEvent     <= 1'b0;
			noReadEvent       <= 1'b0;
			codeTxStrobe      <= 1'b0;
			codeTxData        <= '0;
			noReadMsgStrobe   <= 1'b0;
			wrongStringStrobe <= 1'b0;
		end else begin
			goodReadEvent     <= phaseClose && gotCode_q && !mismatch;
			noReadEvent       <= phaseClose && !gotCode_q;
			noReadMsgStrobe   <= phaseClose && !gotCode_q;
			codeTxStrobe      <= phaseClose && gotCode_q && (!mismatch || wrongCodeTxEnable);
			wrongStringStrobe <= phaseClose && gotCode_q && mismatch && wrongStringTxEnable;
			if (phaseClose && gotCode_q)
				codeTxData <= lastCode_q;
			if (operatingMode == RPC_MODE_CONTINUOUS && decodeValid) begin
				codeTxStrobe  <= 1'b1;
				goodReadEvent <= 1'b1;
				codeTxData    <= decodeData;
			end
		end
	end
endmodule : rpc_phase_ctrl

`default_nettype wire

// ===== test/rpc_phase_ctrl_sva.sv
// rpc_phase_ctrl_sva.sv: port checker for the reading phase controller
// assumes a bind into rpc_phase_ctrl, one clock domain
`include "rpc_params.svh"
`default_nettype none
module rpc_phase_ctrl_sva #(
	parameter int CODE_LEN = 32,
	parameter int TMO_W    = 14
) (
	input wire logic                  clock,
	input wire logic                  reset,
	input wire rpc_pkg::rpc_mode_t    operatingMode,
	input wire rpc_pkg::rpc_source_t  triggerSource,
	input wire logic                  busStartEnable,
	input wire logic [7:0]            controlBitByte,
	input wire logic [TMO_W-1:0]      timeoutMs,
	input wire logic                  timeoutFromStop,
	input wire logic                  stopPriorityTimeout,
	input wire logic                  serialStartRx,
	input wire logic                  serialStopRx,
	input wire logic                  decodeValid,
	input wire logic [8*CODE_LEN-1:0] decodeData,
	input wire logic                  verifierEnable,
	input wire logic                  readingPhase,
	input wire logic                  goodReadEvent,
	input wire logic                  noReadEvent,
	input wire logic                  codeTxStrobe,
	input wire logic [8*CODE_LEN-1:0] codeTxData,
	input wire logic                  noReadMsgStrobe,
	input wire logic                  timeoutValid
);
	timeunit 1ns;
	timeprecision 1ns;
	import rpc_pkg::*;
	logic cont;
	logic ser;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	assign cont = operatingMode == RPC_MODE_CONTINUOUS;
	assign ser = !cont && triggerSource == RPC_SRC_SERIAL && !busStartEnable;
	// ----------
	// properties
	// ----------
	cont_phase_a: assert property (cont && $past(cont) |-> readingPhase)
		else $error("phase closed in continuous mode");
	cont_noread_a: assert property (cont && $past(cont) |-> !noReadEvent && !noReadMsgStrobe)
		else $error("no-read in continuous mode");
	cont_tx_a: assert property (cont && decodeValid && !verifierEnable |=>
		codeTxStrobe && goodReadEvent && codeTxData == $past(decodeData))
		else $error("continuous decode not sent");
	ser_open_a: assert property (ser && serialStartRx && !readingPhase |=> readingPhase)
		else $error("start string did not open");
	ser_close_a: assert property (ser && readingPhase && serialStopRx && !timeoutFromStop
		&& !stopPriorityTimeout && !verifierEnable |=> !readingPhase && (goodReadEvent != noReadEvent))
		else $error("stop string close wrong");
	good_tx_a: assert property (goodReadEvent && !verifierEnable |-> codeTxStrobe)
		else $error("good read without code");
	noread_msg_a: assert property (noReadEvent |-> noReadMsgStrobe && !codeTxStrobe)
		else $error("no-read without message");
	close_result_a: assert property ($fell(readingPhase) && !cont && !verifierEnable
		|-> goodReadEvent || noReadEvent)
		else $error("phase end without result");
	tmo_range_a: assert property (timeoutValid == (timeoutMs >= `RPC_TMO_MIN_MS
		&& timeoutMs <= `RPC_TMO_MAX_MS))
		else $error("timeout range flag wrong");
	bus_start_a: assert property (!cont && triggerSource == RPC_SRC_ONE_INPUT && busStartEnable
		&& $rose(controlBitByte[`RPC_BUS_START_BIT]) && !readingPhase |-> ##[1:4] readingPhase)
		else $error("bus bit did not open");
	cover property (ser && serialStopRx && readingPhase);
	cover property ($fell(readingPhase) && timeoutFromStop);
	cover property (cont && decodeValid);
endmodule // rpc_phase_ctrl_sva
bind rpc_phase_ctrl rpc_phase_ctrl_sva #(.CODE_LEN(CODE_LEN), .TMO_W(TMO_W)) rpc_phase_ctrl_sva_i (.*);
`default_nettype wire

// ===== test/rpc_sensor_model.sv
// rpc_sensor_model.sv: presence sensors wired to the input pins
// assumes the bench commands presence and contact wiring per input
`default_nettype none
module rpc_sensor_model (
	input  wire logic       clock,
	input  wire logic [3:0] present,
	input  wire logic [3:0] closedActive,
	output logic [3:0]      inputPins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] level;
	logic       spare = 1'b0;
	// input 2 has no sensor: it toggles so a stray use shows up
	always @(posedge clock) spare <= !spare;
	assign level = ~(present ^ closedActive);
	assign inputPins = {level[3:2], spare, level[0]};
endmodule // rpc_sensor_model
`default_nettype wire

// ===== test/tb_rpc_phase_ctrl.sv
// tb_rpc_phase_ctrl.sv: self-checking bench for the phase controller
// assumes rpc_pkg, the sensor model and the checker compiled first
`include "rpc_params.svh"
`default_nettype none
module tb_rpc_phase_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import rpc_pkg::*;
	localparam int TICK = 4;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [3:0] inputPins, present, closedActive;
	rpc_mode_t operatingMode;
	rpc_source_t triggerSource;
	logic [1:0] startInputSel, stopInputSel, storeInputSel;
	rpc_level_t startActiveLevel, stopActiveLevel, storeActiveLevel;
	logic extendedPhase, busStartEnable, timeoutEnable, timeoutFromStop, stopPriorityTimeout;
	logic serialStartRx, serialStopRx, decodeValid, verifierEnable, wrongCodeTxEnable, wrongStringTxEnable;
	logic readingPhase, goodReadEvent, noReadEvent, codeTxStrobe, noReadMsgStrobe, wrongStringStrobe, timeoutValid;
	logic [7:0] controlBitByte, debounceMs;
	logic [13:0] timeoutMs;
	logic [13:0] tv [4] = '{14'h0027, 14'h0028, 14'h3a98, 14'h3a99};
	logic [255:0] decodeData, codeTxData, referenceCode, lastTx, code;
	int err_count, checks_done, nGood, nNo, nWs, nMsg, seed, g, nr, m, w, n;
	rpc_phase_ctrl #(.TICK_CYCLES(TICK)) rpc_phase_ctrl_i (.*);
	rpc_sensor_model rpc_sensor_model_i (.*);
	always #50 clock = ~clock;
	always @(posedge clock) begin
		if (goodReadEvent === 1'b1) nGood++;
		if (noReadEvent === 1'b1) nNo++;
		if (noReadMsgStrobe === 1'b1) nMsg++;
		if (wrongStringStrobe === 1'b1) nWs++;
		if (codeTxStrobe === 1'b1) lastTx = codeTxData;
	end
	// ---------------
	// helpers
	// ---------------
	function automatic logic [255:0] randCode();
		logic [255:0] c;
		for (int i = 0; i < 32; i++) c[8*i+:8] = 8'($unsigned($random(seed)) % 127);
		return c;
	endfunction
	function automatic logic tmoOk(input logic [13:0] ms);
		return ms >= `RPC_TMO_MIN_MS && ms <= `RPC_TMO_MAX_MS;
	endfunction
	// cycles from the held-past-stop check to the close; the start-based count lost 16 cycles
	function automatic int tmoCycles(input logic fromStop);
		return int'(timeoutMs) * TICK - (fromStop ? 2 : 16);
	endfunction
	function automatic int pinOf(input int k);
		return k == 0 ? 0 : k + 1;
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask
	task automatic checkBit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	task automatic checkData(input logic [255:0] got, input logic [255:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	task automatic sendStr(input logic stop);
		@(posedge clock);
		serialStartRx <= !stop;
		serialStopRx <= stop;
		@(posedge clock);
		serialStartRx <= 1'b0;
		serialStopRx <= 1'b0;
	endtask
	task automatic decode(input logic [255:0] d);
		@(posedge clock);
		decodeData <= d;
		decodeValid <= 1'b1;
		@(posedge clock);
		decodeValid <= 1'b0;
	endtask
	task automatic readPass(input logic [255:0] d);
		sendStr(1'b0);
		decode(d);
		sendStr(1'b1);
		cyc(3);
	endtask
	task automatic waitPhase(input logic exp, input int limit);
		n = 0;
		while (readingPhase !== exp && n < limit) begin
			@(posedge clock);
			n++;
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		cyc(10000);
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict();
	end
	// ---------------
	// scenarios
	// ---------------
	initial begin
		seed = 32'h0054;
		present = 4'h0;
		closedActive = 4'hf;
		operatingMode = RPC_MODE_ONLINE;
		triggerSource = RPC_SRC_SERIAL;
		{startInputSel, stopInputSel, storeInputSel} = 6'h03;
		startActiveLevel = RPC_ACTIVE_CLOSED;
		stopActiveLevel = RPC_ACTIVE_CLOSED;
		storeActiveLevel = RPC_ACTIVE_CLOSED;
		{extendedPhase, busStartEnable, timeoutEnable, timeoutFromStop, stopPriorityTimeout} = 5'h00;
		{serialStartRx, serialStopRx, decodeValid, verifierEnable, wrongCodeTxEnable, wrongStringTxEnable} = 6'h00;
		controlBitByte = 8'h00;
		debounceMs = 8'h02;
		timeoutMs = 14'h0028;
		decodeData = '0;
		cyc(12);
		reset <= 1'b0;
		foreach (tv[i]) begin
			timeoutMs <= tv[i];
			cyc(2);
			checkBit(timeoutValid, tmoOk(tv[i]), "timeout range flag");
		end
		timeoutMs <= 14'h0028;
		for (int i = 0; i < 6; i++) begin
			code = randCode();
			g = nGood;
			nr = nNo;
			m = nMsg;
			decode(randCode());
			sendStr(1'b0);
			waitPhase(1'b1, 4);
			checkBit(readingPhase, 1'b1, "serial open");
			if (i[0]) decode(code);
			cyc(1 + $unsigned($random(seed)) % 5);
			sendStr(1'b1);
			cyc(3);
			checkBit(readingPhase, 1'b0, "serial close");
			checkBit(nGood != g, i[0], "good read");
			checkBit(nNo != nr, !i[0], "no read");
			checkBit(nMsg != m, !i[0], "no read message");
			if (i[0]) checkData(lastTx, code, "code sent");
		end
		timeoutEnable <= 1'b1;
		for (int j = 0; j < 2; j++) begin
			timeoutFromStop <= j[0];
			stopPriorityTimeout <= !j[0];
			nr = nNo;
			sendStr(1'b0);
			cyc(12);
			sendStr(1'b1);
			cyc(2);
			checkBit(readingPhase, 1'b1, "held past stop");
			waitPhase(1'b0, 300);
			checkBit(n > tmoCycles(j[0]) - 8 && n < tmoCycles(j[0]) + 8, 1'b1, "timeout span");
			cyc(2);
			checkBit(nNo != nr, 1'b1, "timeout no read");
		end
		timeoutEnable <= 1'b0;
		triggerSource <= RPC_SRC_ONE_INPUT;
		for (int k = 0; k < 6; k++) begin
			startInputSel <= 2'(k % 3);
			startActiveLevel <= rpc_level_t'(1'(k / 3));
			closedActive <= {4{1'(k / 3)}};
			g = nGood;
			nr = nNo;
			cyc(4);
			present[pinOf(k % 3)] <= 1'b1;
			cyc(4);
			present <= 4'h0;
			waitPhase(1'b1, 30);
			checkBit(readingPhase, 1'b0, "short pulse ignored");
			present[pinOf(k % 3)] <= 1'b1;
			waitPhase(1'b1, 30);
			checkBit(readingPhase === 1'b1 && n >= 8, 1'b1, "sensor open");
			if (k[0]) decode(randCode());
			cyc(3);
			present <= 4'h0;
			waitPhase(1'b0, 30);
			cyc(3);
			checkBit(nGood != g, k[0], "end good read");
			checkBit(nNo != nr, !k[0], "end no read");
		end
		triggerSource <= RPC_SRC_TWO_INPUT;
		startInputSel <= 2'h0;
		stopInputSel <= 2'h1;
		for (int e = 0; e < 2; e++) begin
			extendedPhase <= e[0];
			present[0] <= 1'b1;
			waitPhase(1'b1, 30);
			present[2] <= 1'b1;
			cyc(20);
			present[2] <= 1'b0;
			cyc(30);
			checkBit(readingPhase, e[0], "stop release");
			present[0] <= 1'b0;
			cyc(30);
			checkBit(readingPhase, 1'b0, "both released");
		end
		triggerSource <= RPC_SRC_ONE_INPUT;
		busStartEnable <= 1'b1;
		controlBitByte <= 8'h7f;
		cyc(6);
		checkBit(readingPhase, 1'b0, "low bits idle");
		controlBitByte <= 8'h80 | 8'($random(seed));
		cyc(6);
		checkBit(readingPhase, 1'b1, "bus start");
		controlBitByte <= 8'h00;
		cyc(6);
		checkBit(readingPhase, 1'b0, "bus stop");
		busStartEnable <= 1'b0;
		triggerSource <= RPC_SRC_SERIAL;
		{verifierEnable, wrongCodeTxEnable, wrongStringTxEnable} <= 3'h7;
		storeInputSel <= 2'h1;
		storeActiveLevel <= RPC_ACTIVE_OPEN;
		closedActive <= 4'hb;
		code = randCode();
		// store held across the whole phase
		present[2] <= 1'b1;
		cyc(4);
		readPass(code);
		present[2] <= 1'b0;
		// let the released store input pass the synchroniser before the next start
		cyc(4);
		checkData(referenceCode, code, "stored reference");
		for (int j = 0; j < 2; j++) begin
			g = nGood;
			w = nWs;
			if (j == 1) code = randCode();
			readPass(code);
			checkBit(nGood != g, !j[0], "verify good");
			checkBit(nWs != w, j[0], "mismatch string");
			checkData(lastTx, code, "code sent");
		end
		verifierEnable <= 1'b0;
		operatingMode <= RPC_MODE_CONTINUOUS;
		cyc(2);
		checkBit(readingPhase, 1'b1, "always open");
		nr = nNo;
		code = randCode();
		decode(code);
		sendStr(1'b1);
		cyc(3);
		checkData(lastTx, code, "continuous tx");
		checkBit(readingPhase === 1'b1 && nNo == nr, 1'b1, "no close");
		print_verdict();
	end
endmodule // tb_rpc_phase_ctrl
`default_nettype wire
